/* rtl/ifd_map.svh */
`ifndef IFD_MAP_SVH
`define IFD_MAP_SVH
// ****************************************************************************
// Slave address
// ****************************************************************************
`define IFD_ADDR_DEFAULT 7'h43
`define IFD_ADDR_A3 3
`define IFD_ADDR_A0 0
// ****************************************************************************
// Register select byte decode
// ****************************************************************************
`define IFD_SUB_SWITCH 2'h0
`define IFD_SUB_ADJUST 2'h1
`define IFD_SUB_DATA 2'h2
`define IFD_SUB_LAST 2'h3
`define IFD_SUB_HI 1
`define IFD_SUB_LO 0
// ****************************************************************************
// Power-on presets
// ****************************************************************************
`define IFD_SWITCH_RST 8'hD6
`define IFD_ADJUST_RST 8'h30
`define IFD_DATA_RST_STRAP 8'h00
`define IFD_DATA_RST_OPEN 8'h04
// ****************************************************************************
// Switching register fields
// ****************************************************************************
`define IFD_SW_PORT2 7
`define IFD_SW_PORT1 6
`define IFD_SW_MUTE 5
`define IFD_SW_STD_HI 4
`define IFD_SW_STD_LO 3
`define IFD_SW_QSS 2
`define IFD_SW_AUTOMUTE 1
`define IFD_SW_TRAP 0
// ****************************************************************************
// Adjust register fields
// ****************************************************************************
`define IFD_ADJ_GAIN 7
`define IFD_ADJ_DE50 6
`define IFD_ADJ_DEON 5
`define IFD_ADJ_TOP_HI 4
`define IFD_ADJ_TOP_LO 0
// ****************************************************************************
// Receiver status fields
// ****************************************************************************
`define IFD_ST_WIN 7
`define IFD_ST_LEV 6
`define IFD_ST_CAR 5
`define IFD_ST_OFS_HI 4
`define IFD_ST_OFS_LO 1
`define IFD_ST_PON 0
// ****************************************************************************
// Counts
// ****************************************************************************
`define IFD_BIT_LAST 3'h7
`define IFD_BIT_ONE 3'h1
`define IFD_BIT_ZERO 3'h0
`define IFD_STRAP_WAIT 2'h3
`define IFD_STRAP_ONE 2'h1
`define IFD_SYNC_IN_W 12
`define IFD_SYNC_LNK_W 2
`endif

/* rtl/ifd_pkg.sv */
package ifd_pkg;
  typedef logic [7:0] ifd_byte_t;
  typedef enum logic [8:0] {
    IFD_ST_ADDR     = 9'h001,
    IFD_ST_ADDR_ACK = 9'h002,
    IFD_ST_SUB      = 9'h004,
    IFD_ST_SUB_ACK  = 9'h008,
    IFD_ST_WDATA    = 9'h010,
    IFD_ST_WACK     = 9'h020,
    IFD_ST_RDATA    = 9'h040,
    IFD_ST_RACK     = 9'h080,
    IFD_ST_IGNORE   = 9'h100
  } ifd_link_state_e;
endpackage

/* rtl/ifd_serial_ctrl.sv */
// Behaviour
// - Read: send status byte, MSB first.
// - Answer 43, 42, 4B or 4A hex.
// - Straps clear A0 and set A3.
// - Status bit layout window, level, carrier, offset, power.
// - Window flag reported as the analog path gives.
// - Level and carrier flags reported as given.
// - Power flag set by reset, cleared by read.
// - Offset code passed through as signed code.
// - Write: address, select byte, data, all acked.
// - Auto-increment select, stopping at three.
// - Decode select bits one and zero only.
// - Switching bits seven, six drive ports.
// - Bit five forces mute, bit one automute.
// - Bit two split sound, bit zero trap.
// - Bits four, three pick the standard.
// - Adjust bits set gain and de-emphasis.
// - Adjust low bits set takeover point.
// - Presets D6, 30, data by strap.
// - Runs at bus clocks up to 400 kHz.
`timescale 1ns/1ns
`include "ifd_map.svh"
module ifd_serial_ctrl (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  input wire logic intercarrier_strap_i,
  input wire logic sound_if_strap_i,
  input wire logic freq_window_flag_i,
  input wire logic input_level_flag_i,
  input wire logic carrier_detect_flag_i,
  input wire logic [3:0] freq_offset_code_i,
  input wire logic supply_fail_i,
  output logic output_port_one_o,
  output logic output_port_one_oe_n_o,
  output logic output_port_two_o,
  output logic output_port_two_oe_n_o,
  output logic audio_mute_o,
  output logic auto_mute_en_o,
  output logic [1:0] standard_select_field_o,
  output logic fm_radio_mode_o,
  output logic quasi_split_sound_o,
  output logic trap_bypass_o,
  output logic audio_gain_reduced_o,
  output logic deemph_50us_o,
  output logic deemph_on_o,
  output logic [4:0] takeover_point_field_o,
  output ifd_pkg::ifd_byte_t data_control_o
);
  import ifd_pkg::*;

  // **************************************************************************
  // Core domain: input synchronisers and bus condition detection
  // **************************************************************************
  logic [`IFD_SYNC_IN_W-1:0] in_s;
  logic [`IFD_SYNC_LNK_W-1:0] lnk_s;
  logic sda_d_reg;
  logic link_hold_reg;
  logic start_pend_reg;
  logic wr_tgl_d_reg;
  logic rd_tgl_d_reg;
  logic [1:0] strap_cnt_reg;
  logic strap_done_reg;
  logic [6:0] addr_reg;
  logic [6:0] addr_sel;
  logic power_on_flag_reg;
  logic power_on_flag_next;
  ifd_byte_t status_live;
  ifd_byte_t status_shadow_reg;
  ifd_byte_t switching_reg;
  ifd_byte_t adjust_reg;
  ifd_byte_t data_reg;
  logic wr_tgl_reg;
  logic rd_tgl_reg;
  logic [1:0] wr_idx_reg;
  ifd_byte_t wr_data_reg;

  ifd_sync2 #(.W(`IFD_SYNC_IN_W)) u_sync_in (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .d_i({supply_fail_i, freq_offset_code_i, carrier_detect_flag_i, input_level_flag_i,
          freq_window_flag_i, sound_if_strap_i, intercarrier_strap_i, sda_i, scl_i}),
    .q_o(in_s)
  );

  ifd_sync2 #(.W(`IFD_SYNC_LNK_W)) u_sync_lnk (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .d_i({rd_tgl_reg, wr_tgl_reg}),
    .q_o(lnk_s)
  );

  wire scl_s = in_s[0];
  wire sda_s = in_s[1];
  wire ic_strap_s = in_s[2];
  wire snd_strap_s = in_s[3];
  wire win_s = in_s[4];
  wire lev_s = in_s[5];
  wire car_s = in_s[6];
  wire [3:0] ofs_s = in_s[10:7];
  wire fail_s = in_s[11];
  wire wr_evt = lnk_s[0] ^ wr_tgl_d_reg;
  wire rd_evt = lnk_s[1] ^ rd_tgl_d_reg;
  // Three core cycles of detection latency sit far inside the SCL low time
  // that a 400 kHz master leaves after START.
  wire start_det = scl_s & sda_d_reg & ~sda_s;
  wire stop_det = scl_s & ~sda_d_reg & sda_s;
  wire strap_take = !strap_done_reg && (strap_cnt_reg == `IFD_STRAP_WAIT);
  wire wr_sw = wr_evt && (wr_idx_reg == `IFD_SUB_SWITCH);
  wire wr_adj = wr_evt && (wr_idx_reg == `IFD_SUB_ADJUST);
  wire wr_dat = wr_evt && (wr_idx_reg == `IFD_SUB_DATA);
  // The link logic is held in reset between frames; it is released only while
  // SCL is low after a START, so no SCL edge can race the release.
  wire link_rst_n = rst_n_i & ~link_hold_reg;

  // **************************************************************************
  // Address straps and status assembly
  // **************************************************************************
  always_comb begin
    addr_sel = `IFD_ADDR_DEFAULT;
    addr_sel[`IFD_ADDR_A3] = snd_strap_s;
    addr_sel[`IFD_ADDR_A0] = ~ic_strap_s;
  end

  always_comb begin
    status_live = '0;
    status_live[`IFD_ST_WIN] = win_s;
    status_live[`IFD_ST_LEV] = lev_s;
    status_live[`IFD_ST_CAR] = car_s;
    status_live[`IFD_ST_OFS_HI:`IFD_ST_OFS_LO] = ofs_s;
    status_live[`IFD_ST_PON] = power_on_flag_reg;
  end

  // A breakdown arriving with the clearing read keeps the flag set.
  assign power_on_flag_next = fail_s ? 1'b1 : (rd_evt ? 1'b0 : power_on_flag_reg);

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sda_d_reg <= 1'b1;
      wr_tgl_d_reg <= 1'b0;
      rd_tgl_d_reg <= 1'b0;
      power_on_flag_reg <= 1'b1;
      status_shadow_reg <= '0;
    end else begin
      sda_d_reg <= sda_s;
      wr_tgl_d_reg <= lnk_s[0];
      rd_tgl_d_reg <= lnk_s[1];
      power_on_flag_reg <= power_on_flag_next;
      if (link_hold_reg) begin
        status_shadow_reg <= status_live;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_cnt_reg <= '0;
      strap_done_reg <= 1'b0;
      addr_reg <= `IFD_ADDR_DEFAULT;
    end else if (!strap_done_reg) begin
      strap_cnt_reg <= 2'(strap_cnt_reg + `IFD_STRAP_ONE);
      if (strap_take) begin
        strap_done_reg <= 1'b1;
        addr_reg <= addr_sel;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      link_hold_reg <= 1'b1;
      start_pend_reg <= 1'b0;
    end else if (!strap_done_reg || stop_det) begin
      link_hold_reg <= 1'b1;
      start_pend_reg <= 1'b0;
    end else if (start_det) begin
      link_hold_reg <= 1'b1;
      start_pend_reg <= 1'b1;
    end else if (start_pend_reg && !scl_s) begin
      link_hold_reg <= 1'b0;
      start_pend_reg <= 1'b0;
    end
  end

  // **************************************************************************
  // Control registers
  // **************************************************************************
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      switching_reg <= `IFD_SWITCH_RST;
      adjust_reg <= `IFD_ADJUST_RST;
      data_reg <= `IFD_DATA_RST_OPEN;
    end else begin
      if (wr_sw) begin
        switching_reg <= wr_data_reg;
      end
      if (wr_adj) begin
        adjust_reg <= wr_data_reg;
      end
      if (strap_take) begin
        data_reg <= ic_strap_s ? `IFD_DATA_RST_STRAP : `IFD_DATA_RST_OPEN;
      end else if (wr_dat) begin
        data_reg <= wr_data_reg;
      end
    end
  end

  // A one releases the port, a zero pulls it low.
  assign output_port_two_o = switching_reg[`IFD_SW_PORT2];
  assign output_port_two_oe_n_o = switching_reg[`IFD_SW_PORT2];
  assign output_port_one_o = switching_reg[`IFD_SW_PORT1];
  assign output_port_one_oe_n_o = switching_reg[`IFD_SW_PORT1];
  assign audio_mute_o = switching_reg[`IFD_SW_MUTE];
  assign auto_mute_en_o = switching_reg[`IFD_SW_AUTOMUTE];
  assign standard_select_field_o = switching_reg[`IFD_SW_STD_HI:`IFD_SW_STD_LO];
  // Both radio codes share a one in the low bit.
  assign fm_radio_mode_o = switching_reg[`IFD_SW_STD_LO];
  assign quasi_split_sound_o = switching_reg[`IFD_SW_QSS];
  assign trap_bypass_o = switching_reg[`IFD_SW_TRAP];
  assign audio_gain_reduced_o = adjust_reg[`IFD_ADJ_GAIN];
  assign deemph_50us_o = adjust_reg[`IFD_ADJ_DE50];
  assign deemph_on_o = adjust_reg[`IFD_ADJ_DEON];
  assign takeover_point_field_o = adjust_reg[`IFD_ADJ_TOP_HI:`IFD_ADJ_TOP_LO];
  assign data_control_o = data_reg;

  // **************************************************************************
  // Link domain: bit engine clocked by SCL
  // **************************************************************************
  ifd_link_state_e state_reg;
  ifd_link_state_e state_next;
  logic [2:0] bit_cnt_reg;
  logic [2:0] bit_cnt_next;
  ifd_byte_t shift_reg;
  ifd_byte_t tx_reg;
  ifd_byte_t tx_next;
  logic [1:0] sub_reg;
  logic [1:0] sub_next;
  logic wr_fire;
  logic rd_fire;
  logic drive_low;
  logic sda_o_reg;
  logic sda_oe_n_reg;

  wire [7:0] rx_byte = {shift_reg[6:0], sda_i};
  wire bit_last = bit_cnt_reg == `IFD_BIT_LAST;
  wire addr_hit = rx_byte[7:1] == addr_reg;

  always_comb begin
    state_next = state_reg;
    bit_cnt_next = 3'(bit_cnt_reg + `IFD_BIT_ONE);
    tx_next = tx_reg;
    sub_next = sub_reg;
    wr_fire = 1'b0;
    rd_fire = 1'b0;
    case (state_reg)
      IFD_ST_ADDR: begin
        if (bit_last) begin
          state_next = addr_hit ? IFD_ST_ADDR_ACK : IFD_ST_IGNORE;
        end
      end
      IFD_ST_ADDR_ACK: begin
        bit_cnt_next = `IFD_BIT_ZERO;
        if (shift_reg[0]) begin
          state_next = IFD_ST_RDATA;
          tx_next = status_shadow_reg;
        end else begin
          state_next = IFD_ST_SUB;
        end
      end
      IFD_ST_SUB: begin
        if (bit_last) begin
          // Bit seven is expected low from the master; bits six to two are dropped.
          sub_next = rx_byte[`IFD_SUB_HI:`IFD_SUB_LO];
          state_next = IFD_ST_SUB_ACK;
        end
      end
      IFD_ST_SUB_ACK: begin
        bit_cnt_next = `IFD_BIT_ZERO;
        state_next = IFD_ST_WDATA;
      end
      IFD_ST_WDATA: begin
        if (bit_last) begin
          wr_fire = 1'b1;
          state_next = IFD_ST_WACK;
        end
      end
      IFD_ST_WACK: begin
        bit_cnt_next = `IFD_BIT_ZERO;
        state_next = IFD_ST_WDATA;
        if (sub_reg != `IFD_SUB_LAST) begin
          sub_next = 2'(sub_reg + `IFD_STRAP_ONE);
        end
      end
      IFD_ST_RDATA: begin
        tx_next = {tx_reg[6:0], 1'b1};
        if (bit_last) begin
          rd_fire = 1'b1;
          state_next = IFD_ST_RACK;
        end
      end
      IFD_ST_RACK: begin
        bit_cnt_next = `IFD_BIT_ZERO;
        if (!sda_i) begin
          state_next = IFD_ST_RDATA;
          tx_next = status_shadow_reg;
        end else begin
          state_next = IFD_ST_IGNORE;
        end
      end
      IFD_ST_IGNORE: begin
        bit_cnt_next = `IFD_BIT_ZERO;
      end
      default: begin
        state_next = IFD_ST_IGNORE;
      end
    endcase
  end

  always_ff @(posedge scl_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      state_reg <= IFD_ST_ADDR;
      bit_cnt_reg <= '0;
      shift_reg <= '0;
      tx_reg <= '0;
      sub_reg <= '0;
    end else begin
      state_reg <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= rx_byte;
      tx_reg <= tx_next;
      sub_reg <= sub_next;
    end
  end

  // Hand-off words survive the frame reset; the toggles mark each new word.
  always_ff @(posedge scl_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_tgl_reg <= 1'b0;
      rd_tgl_reg <= 1'b0;
      wr_idx_reg <= '0;
      wr_data_reg <= '0;
    end else begin
      if (wr_fire) begin
        wr_tgl_reg <= ~wr_tgl_reg;
        wr_idx_reg <= sub_reg;
        wr_data_reg <= rx_byte;
      end
      if (rd_fire) begin
        rd_tgl_reg <= ~rd_tgl_reg;
      end
    end
  end

  assign drive_low = (state_reg == IFD_ST_ADDR_ACK) || (state_reg == IFD_ST_SUB_ACK) ||
                     (state_reg == IFD_ST_WACK) ||
                     ((state_reg == IFD_ST_RDATA) && !tx_reg[7]);

  always_ff @(negedge scl_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      sda_o_reg <= 1'b1;
      sda_oe_n_reg <= 1'b1;
    end else begin
      sda_o_reg <= ~drive_low;
      sda_oe_n_reg <= ~drive_low;
    end
  end

  assign sda_o = sda_o_reg;
  assign sda_oe_n_o = sda_oe_n_reg;

  // **************************************************************************
  // Assertions
  // **************************************************************************
  property p_pon_clear;
    @(posedge core_clk_i) disable iff (!rst_n_i) rd_evt && !fail_s |=> !power_on_flag_reg;
  endproperty
  a_pon_clear: assert property (p_pon_clear) else $error("power flag not cleared");

  property p_pon_set;
    @(posedge core_clk_i) disable iff (!rst_n_i) fail_s |=> power_on_flag_reg [*2];
  endproperty
  a_pon_set: assert property (p_pon_set) else $error("power flag not set");

  property p_port_two;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      wr_sw |=> output_port_two_oe_n_o == $past(wr_data_reg[`IFD_SW_PORT2]);
  endproperty
  a_port_two: assert property (p_port_two) else $error("port two not updated");

  property p_data_strap;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      strap_take |=> data_reg == ($past(ic_strap_s) ? `IFD_DATA_RST_STRAP : `IFD_DATA_RST_OPEN);
  endproperty
  a_data_strap: assert property (p_data_strap) else $error("data preset wrong");

  property p_status_pon;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      link_hold_reg |=> status_shadow_reg[`IFD_ST_PON] == $past(power_on_flag_reg);
  endproperty
  a_status_pon: assert property (p_status_pon) else $error("status bit 0 wrong");

  property p_ack_drive;
    @(posedge scl_i) disable iff (!link_rst_n)
      (state_reg == IFD_ST_ADDR_ACK) || (state_reg == IFD_ST_WACK) |-> !sda_oe_n_reg;
  endproperty
  a_ack_drive: assert property (p_ack_drive) else $error("ack not driven");

  property p_foreign;
    @(posedge scl_i) disable iff (!link_rst_n)
      state_reg == IFD_ST_ADDR && bit_last && !addr_hit |=> state_reg == IFD_ST_IGNORE ##0
      sda_oe_n_reg;
  endproperty
  a_foreign: assert property (p_foreign) else $error("foreign address taken");

  property p_sub_stop;
    @(posedge scl_i) disable iff (!link_rst_n)
      state_reg == IFD_ST_WACK && sub_reg == `IFD_SUB_LAST |=> sub_reg == `IFD_SUB_LAST;
  endproperty
  a_sub_stop: assert property (p_sub_stop) else $error("select ran past three");

  property p_resend;
    @(posedge scl_i) disable iff (!link_rst_n)
      state_reg == IFD_ST_RACK && !sda_i |=> state_reg == IFD_ST_RDATA &&
      tx_reg == status_shadow_reg;
  endproperty
  a_resend: assert property (p_resend) else $error("status not resent");
endmodule

/* rtl/ifd_sync2.sv */
`timescale 1ns/1ns
module ifd_sync2 #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= '0;
      q_reg <= '0;
    end else begin
      meta_reg <= d_i;
      q_reg <= meta_reg;
    end
  end

  assign q_o = q_reg;
endmodule

/* verification/if_demod_serial_ctrl_bench.sv */
`timescale 1ns/1ns
module if_demod_serial_ctrl_bench;
  logic clk, rst_n, scl, m_low, sda, sda_o, sda_oe_n, ic, sif, win, lev, car, sfail;
  logic [3:0] ofs;
  logic p1, p1_oe_n, p2, p2_oe_n, mute, am, radio, quasi_split_sound, trap, gain, de50, deon;
  logic [1:0] std;
  logic [4:0] top;
  ifd_pkg::ifd_byte_t data_q;
  logic [7:0] regm [3];
  logic [31:0] rnd;
  int fails = 0;
  int comparisons = 0;

  // ****************************************************************************
  // Wire resolution, partner and design.
  // ****************************************************************************
  assign sda = (sda_oe_n | sda_o) & ~m_low;

  ifd_master m (.scl_o(scl), .sda_low_o(m_low), .sda_i(sda));

  ifd_serial_ctrl dut (
    .core_clk_i(clk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n), .intercarrier_strap_i(ic), .sound_if_strap_i(sif),
    .freq_window_flag_i(win), .input_level_flag_i(lev), .carrier_detect_flag_i(car),
    .freq_offset_code_i(ofs), .supply_fail_i(sfail), .output_port_one_o(p1),
    .output_port_one_oe_n_o(p1_oe_n), .output_port_two_o(p2),
    .output_port_two_oe_n_o(p2_oe_n), .audio_mute_o(mute), .auto_mute_en_o(am),
    .standard_select_field_o(std), .fm_radio_mode_o(radio), .quasi_split_sound_o(quasi_split_sound),
    .trap_bypass_o(trap), .audio_gain_reduced_o(gain), .deemph_50us_o(de50),
    .deemph_on_o(deon), .takeover_point_field_o(top), .data_control_o(data_q)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ****************************************************************************
  // Helpers.
  // ****************************************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_regs();
    chk("switching", regm[0], {p2, p1, mute, std, quasi_split_sound, am, trap});
    chk("port_oe", {6'h00, regm[0][7:6]}, {6'h00, p2_oe_n, p1_oe_n});
    chk("radio", {7'h00, regm[0][3]}, {7'h00, radio});
    chk("adjust", regm[1], {gain, de50, deon, top});
    chk("data", regm[2], data_q);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] sel, input int n, input logic ea);
    logic ak;
    logic [7:0] d;
    int k;
    m.start();
    m.send({a, 1'b0}, ak);
    chk("addr_ack", {7'h00, ea}, {7'h00, ak});
    if (ea) begin
      m.send(sel, ak);
      chk("sel_ack", 8'h01, {7'h00, ak});
      for (int i = 0; i < n; i++) begin
        rnd = lfsr(rnd);
        d = rnd[7:0];
        m.send(d, ak);
        chk("data_ack", 8'h01, {7'h00, ak});
        k = int'(sel[1:0]) + i;
        if (k < 3) begin
          regm[k] = d;
        end
      end
    end
    m.stop();
    repeat (10) @(posedge clk);
  endtask

  task automatic rd(input logic [6:0] a, input int n, input logic [7:0] e);
    logic ak;
    logic [7:0] d;
    m.start();
    m.send({a, 1'b1}, ak);
    chk("rd_ack", 8'h01, {7'h00, ak});
    for (int i = 0; i < n; i++) begin
      m.recv(i < n - 1, d);
      chk("status", e, d);
    end
    m.stop();
    repeat (10) @(posedge clk);
  endtask

  // ****************************************************************************
  // Main sequence.
  // ****************************************************************************
  initial begin
    logic [6:0] addr;
    logic [7:0] st;
    rst_n = 1'b0;
    {ic, sif, win, lev, car, ofs, sfail} = 10'h000;
    rnd = 32'h056A4DFC;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      #1;
      rst_n = 1'b0;
      ic = k[0];
      sif = k[1];
      repeat (3) @(posedge clk);
      #1 rst_n = 1'b1;
      repeat (10) @(posedge clk);
      addr = (7'h43 & ~{6'h00, ic}) | {3'h0, sif, 3'h0};
      regm[0] = 8'hD6;
      regm[1] = 8'h30;
      regm[2] = ic ? 8'h00 : 8'h04;
      chk_regs();
      wr(addr ^ 7'h01, 8'h00, 1, 1'b0);
      wr(addr ^ 7'h08, 8'h00, 1, 1'b0);
      chk_regs();
      @(posedge clk);
      #1;
      rnd = lfsr(rnd);
      {win, lev, car, ofs} = rnd[6:0];
      st = {rnd[6:0], 1'b1};
      repeat (10) @(posedge clk);
      rd(addr, 2, st);
      rd(addr, 1, {st[7:1], 1'b0});
      rnd = lfsr(rnd);
      wr(addr, {1'b0, rnd[6:2], k[1:0]}, 4, 1'b1);
      chk_regs();
      @(posedge clk);
      #1 sfail = 1'b1;
      @(posedge clk);
      #1 sfail = 1'b0;
      repeat (10) @(posedge clk);
      rd(addr, 1, st);
      $display("strap set %0d done", k);
    end
    wrap_up();
  end

  initial begin
    repeat (100000) @(posedge clk);
    fails++;
    wrap_up();
  end
endmodule

/* verification/ifd_master.sv */
`timescale 1ns/1ns
module ifd_master (
  output logic scl_o,
  output logic sda_low_o,
  input wire logic sda_i
);
  // ****************************************************************************
  // Two-wire master; the bus clock stands high between frames.
  // ****************************************************************************
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  task automatic put_bit(input logic b);
    #4 sda_low_o = ~b;
    #12 scl_o = 1'b1;
    #16 scl_o = 1'b0;
  endtask

  task automatic get_bit(output logic b);
    #4 sda_low_o = 1'b0;
    #12 scl_o = 1'b1;
    b = sda_i;
    #16 scl_o = 1'b0;
  endtask

  // Generous low time after the start lets the core see the frame open.
  task automatic start();
    sda_low_o = 1'b1;
    #100 scl_o = 1'b0;
    #100;
  endtask

  task automatic stop();
    #4 sda_low_o = 1'b1;
    #16 scl_o = 1'b1;
    #50 sda_low_o = 1'b0;
    #100;
  endtask

  task automatic send(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i]);
    end
    get_bit(b);
    ack = ~b;
  endtask

  task automatic recv(input logic more, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      get_bit(d[i]);
    end
    put_bit(~more);
  endtask
endmodule
